// >>> hw/i2chs_pkg.sv
// Constants shared by the two-wire master handshake design.
// Assumes nothing beyond a SystemVerilog compiler.
package i2chs_pkg;
	// Status codes, low three bits always zero
	localparam logic [7:0] ST_START     = 8'h08;
	localparam logic [7:0] ST_ADDR_ACK  = 8'h18;
	localparam logic [7:0] ST_ADDR_NACK = 8'h20;
	localparam logic [7:0] ST_DATA_ACK  = 8'h28;
	localparam logic [7:0] ST_DATA_NACK = 8'h30;
	localparam logic [7:0] ST_NO_INFO   = 8'hF8;
	localparam int         FIFO_DEPTH   = 16;
	localparam int         BYTE_W       = 8;
	localparam int         HALF_CYC     = 4;
	localparam logic [2:0] LAST_BIT     = 3'h7;
	typedef enum logic [1:0] {
		OP_START = 2'b00,
		OP_BYTE  = 2'b01,
		OP_STOP  = 2'b10
	} i2chs_op_t;
	typedef enum logic [3:0] {
		LK_IDLE   = 4'b0000,
		LK_ST_A   = 4'b0001,
		LK_ST_B   = 4'b0010,
		LK_HOLD   = 4'b0011,
		LK_BIT_LO = 4'b0100,
		LK_BIT_HI = 4'b0101,
		LK_ACK_LO = 4'b0110,
		LK_ACK_HI = 4'b0111,
		LK_SP_A   = 4'b1000,
		LK_SP_B   = 4'b1001,
		LK_SP_C   = 4'b1010,
		LK_RS_A   = 4'b1011,
		LK_RS_B   = 4'b1100
	} i2chs_lk_t;
endpackage

// >>> hw/i2chs_fifo.sv
// Byte FIFO with valid/ready on both sides, flip-flop storage.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module i2chs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    rd_ptr, next_rd_ptr, wr_ptr, next_wr_ptr;
	logic [AW:0]      count, next_count;
	logic             push, pop;

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];

	always_comb begin
		push        = in_valid && in_ready;
		pop         = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count  <= '0;
		end else begin
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			count  <= next_count;
		end
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule
`default_nettype wire

// >>> hw/i2chs_master.sv
// Two-wire master with completion-flag handshake toward software.
// Assumes pull-ups on both lines; control bits arrive as plain ports.
`timescale 1ns/1ps
`default_nettype none
module i2chs_master #(
	parameter int HALF = i2chs_pkg::HALF_CYC,
	parameter int DEPTH = i2chs_pkg::FIFO_DEPTH
) (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       link_clk,
	input  wire logic       ctrl_wr,
	input  wire logic       ctrl_flag,
	input  wire logic       ctrl_enable,
	input  wire logic       ctrl_start,
	input  wire logic       ctrl_stop,
	input  wire logic       irq_enable_bit,
	input  wire logic       global_irq_en,
	input  wire logic       data_valid,
	output logic            data_ready,
	input  wire logic [7:0] data_in,
	output logic            flag,
	output logic [7:0]      bus_status_reg,
	output logic [7:0]      byte_shift_reg,
	output logic            irq_req,
	output logic            busy,
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe
);
	import i2chs_pkg::*;

	////////////////////////////////////////////////////////////////////
	// System domain
	logic       fifo_rdy, fifo_vld, fifo_pop;
	logic [7:0] fifo_dat;
	logic       next_flag, next_busy, next_irq, next_after_start;
	logic       after_start, req_tgl, next_req_tgl, dn_s1, dn_s2, dn_s3;
	logic [7:0] next_status, pend_code, next_pend, next_byte;
	i2chs_op_t  cmd_op, next_cmd_op;
	logic       go, done_evt, in_rdy_q;
	logic       lk_done_tgl, lk_done_stop, lk_ack;

	i2chs_fifo #(.WIDTH(BYTE_W), .DEPTH(DEPTH)) u_fifo (
		.clock    (clock),
		.rst      (rst),
		.in_valid (data_valid),
		.in_ready (fifo_rdy),
		.in_data  (data_in),
		.out_valid(fifo_vld),
		.out_ready(fifo_pop),
		.out_data (fifo_dat)
	);

	always_comb begin
		done_evt = dn_s2 ^ dn_s3;
		go = ctrl_wr && ctrl_flag && ctrl_enable && !busy;
		next_cmd_op = cmd_op;
		if (go) begin
			if (ctrl_stop) begin
				next_cmd_op = OP_STOP;
			end else if (ctrl_start) begin
				next_cmd_op = OP_START;
			end else begin
				next_cmd_op = OP_BYTE;
			end
		end
		fifo_pop  = go && !ctrl_stop && !ctrl_start;
		next_byte = (fifo_pop && fifo_vld) ? fifo_dat : byte_shift_reg;
		next_req_tgl = go ? !req_tgl : req_tgl;
		next_busy = go || (busy && !done_evt);
		next_flag = (done_evt && !lk_done_stop)
			|| (flag && !(ctrl_wr && ctrl_flag));
		next_after_start = after_start;
		next_pend = pend_code;
		if (done_evt && !lk_done_stop) begin
			case (cmd_op)
				OP_START: begin
					next_pend = ST_START;
					next_after_start = 1'b1;
				end
				OP_BYTE: begin
					if (after_start) begin
						next_pend = lk_ack ? ST_ADDR_NACK : ST_ADDR_ACK;
					end else begin
						next_pend = lk_ack ? ST_DATA_NACK : ST_DATA_ACK;
					end
					next_after_start = 1'b0;
				end
				default: next_pend = ST_NO_INFO;
			endcase
		end
		next_status = flag ? pend_code : ST_NO_INFO;
		next_irq = flag && irq_enable_bit && global_irq_en;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			flag           <= 1'b0;
			busy           <= 1'b0;
			irq_req        <= 1'b0;
			after_start    <= 1'b0;
			req_tgl        <= 1'b0;
			cmd_op         <= OP_START;
			pend_code      <= ST_NO_INFO;
			bus_status_reg <= ST_NO_INFO;
			byte_shift_reg <= '0;
			in_rdy_q       <= 1'b0;
			dn_s1          <= 1'b0;
			dn_s2          <= 1'b0;
			dn_s3          <= 1'b0;
		end else begin
			flag           <= next_flag;
			busy           <= next_busy;
			irq_req        <= next_irq;
			after_start    <= next_after_start;
			req_tgl        <= next_req_tgl;
			cmd_op         <= next_cmd_op;
			pend_code      <= next_pend;
			bus_status_reg <= next_status;
			byte_shift_reg <= next_byte;
			in_rdy_q       <= fifo_rdy;
			dn_s1          <= lk_done_tgl;
			dn_s2          <= dn_s1;
			dn_s3          <= dn_s2;
		end
	end
	// Ready lags one cycle; FIFO still refuses on its own full
	assign data_ready = in_rdy_q;

	chk_flag_clear: assert property (@(posedge clock) disable iff (rst)
		ctrl_wr && ctrl_flag && flag && !done_evt |=> !flag)
		else $error("flag not cleared by one");
	chk_zero_keeps: assert property (@(posedge clock) disable iff (rst)
		flag && !(ctrl_wr && ctrl_flag) |=> flag)
		else $error("flag lost without clear");
	chk_no_op_flag: assert property (@(posedge clock) disable iff (rst)
		flag && !(ctrl_wr && ctrl_flag) |=> $stable(req_tgl))
		else $error("operation began with flag set");
	chk_stop_issue: assert property (@(posedge clock) disable iff (rst)
		go && ctrl_stop |=> req_tgl != $past(req_tgl) && cmd_op == OP_STOP)
		else $error("stop not issued");
	chk_stop_noflag: assert property (@(posedge clock) disable iff (rst)
		done_evt && lk_done_stop && !flag |=> !flag)
		else $error("flag set after stop");
	chk_flag_sets: assert property (@(posedge clock) disable iff (rst)
		done_evt && !lk_done_stop |=> flag ##1 flag || !busy)
		else $error("flag not set after step");
	chk_status_lag: assert property (@(posedge clock) disable iff (rst)
		$rose(flag) |-> bus_status_reg == ST_NO_INFO
		##1 bus_status_reg == pend_code)
		else $error("status timing wrong");
	chk_start_code: assert property (@(posedge clock) disable iff (rst)
		done_evt && !lk_done_stop && cmd_op == OP_START
		|=> ##1 bus_status_reg == ST_START)
		else $error("start code missing");
	chk_irq_gate: assert property (@(posedge clock) disable iff (rst)
		irq_req |-> $past(flag) && $past(irq_enable_bit)
		&& $past(global_irq_en))
		else $error("interrupt without enables");

	////////////////////////////////////////////////////////////////////
	// Link domain
	i2chs_lk_t lk, next_lk;
	logic [7:0] cnt, next_cnt, sh, next_sh;
	logic [2:0] bidx, next_bidx;
	logic       lr1, lrst, rq1, rq2, rq3, sd1, sd2, sc1, sc2;
	logic       scl_lo, next_scl_lo, sda_lo, next_sda_lo;
	logic       next_done_tgl, next_done_stop, next_ack, tick, new_req;

	always_comb begin
		tick    = (cnt == '0);
		new_req = rq2 ^ rq3;
		next_lk = lk;
		next_cnt = tick ? cnt : cnt - 8'h01;
		next_sh = sh;
		next_bidx = bidx;
		next_scl_lo = scl_lo;
		next_sda_lo = sda_lo;
		next_done_tgl = lk_done_tgl;
		next_done_stop = lk_done_stop;
		next_ack = lk_ack;
		case (lk)
			LK_IDLE: if (new_req) begin
				if (cmd_op == OP_START) begin
					next_sda_lo = 1'b1;
					next_cnt = HALF[7:0];
					next_lk = LK_ST_A;
				end else begin
					next_done_tgl = !lk_done_tgl;
					next_done_stop = 1'b1;
				end
			end
			LK_ST_A: if (tick) begin
				next_scl_lo = 1'b1;
				next_cnt = HALF[7:0];
				next_lk = LK_ST_B;
			end
			LK_ST_B: if (tick) begin
				next_done_tgl = !lk_done_tgl;
				next_done_stop = 1'b0;
				next_lk = LK_HOLD;
			end
			LK_HOLD: if (new_req) begin
				next_cnt = HALF[7:0];
				case (cmd_op)
					OP_BYTE: begin
						next_sh = byte_shift_reg;
						next_bidx = LAST_BIT;
						next_sda_lo = !byte_shift_reg[7];
						next_lk = LK_BIT_LO;
					end
					OP_STOP: begin
						next_sda_lo = 1'b1;
						next_lk = LK_SP_A;
					end
					default: begin
						next_sda_lo = 1'b0;
						next_lk = LK_RS_A;
					end
				endcase
			end
			// Data moves only a cycle after the clock fell
			LK_BIT_LO: begin
				next_sda_lo = !sh[7];
				if (tick) begin
					next_scl_lo = 1'b0;
					next_cnt = HALF[7:0];
					next_lk = LK_BIT_HI;
				end
			end
			LK_BIT_HI: if (tick && sc2) begin
				next_scl_lo = 1'b1;
				next_cnt = HALF[7:0];
				next_sh = {sh[6:0], 1'b0};
				if (bidx == '0) begin
					next_lk = LK_ACK_LO;
				end else begin
					next_bidx = bidx - 3'h1;
					next_lk = LK_BIT_LO;
				end
			end
			LK_ACK_LO: begin
				next_sda_lo = 1'b0;
				if (tick) begin
					next_scl_lo = 1'b0;
					next_cnt = HALF[7:0];
					next_lk = LK_ACK_HI;
				end
			end
			LK_ACK_HI: if (tick && sc2) begin
				next_ack = sd2;
				next_scl_lo = 1'b1;
				next_done_tgl = !lk_done_tgl;
				next_done_stop = 1'b0;
				next_lk = LK_HOLD;
			end
			LK_SP_A: if (tick) begin
				next_scl_lo = 1'b0;
				next_cnt = HALF[7:0];
				next_lk = LK_SP_B;
			end
			LK_SP_B: if (tick && sc2) begin
				next_sda_lo = 1'b0;
				next_cnt = HALF[7:0];
				next_lk = LK_SP_C;
			end
			LK_SP_C: if (tick) begin
				next_done_tgl = !lk_done_tgl;
				next_done_stop = 1'b1;
				next_lk = LK_IDLE;
			end
			LK_RS_A: if (tick) begin
				next_scl_lo = 1'b0;
				next_cnt = HALF[7:0];
				next_lk = LK_RS_B;
			end
			LK_RS_B: if (tick && sc2) begin
				next_sda_lo = 1'b1;
				next_cnt = HALF[7:0];
				next_lk = LK_ST_A;
			end
			default: next_lk = LK_IDLE;
		endcase
	end

	always_ff @(posedge link_clk) begin
		lr1  <= rst;
		lrst <= lr1;
		rq1 <= req_tgl;
		rq2 <= rq1;
		sd1 <= sda_in;
		sd2 <= sd1;
		sc1 <= scl_in;
		sc2 <= sc1;
		if (lrst) begin
			lk <= LK_IDLE;
			cnt <= '0;
			sh <= '0;
			bidx <= '0;
			scl_lo <= 1'b0;
			sda_lo <= 1'b0;
			lk_done_tgl <= 1'b0;
			lk_done_stop <= 1'b0;
			lk_ack <= 1'b0;
			rq3 <= 1'b0;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			lk <= next_lk;
			cnt <= next_cnt;
			sh <= next_sh;
			bidx <= next_bidx;
			scl_lo <= next_scl_lo;
			sda_lo <= next_sda_lo;
			lk_done_tgl <= next_done_tgl;
			lk_done_stop <= next_done_stop;
			lk_ack <= next_ack;
			rq3 <= rq2;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end
	// Open drain: enable is the driven-low flop
	assign scl_oe = scl_lo;
	assign sda_oe = sda_lo;

	chk_scl_held: assert property (@(posedge link_clk) disable iff (lrst)
		lk == LK_HOLD && !new_req |=> scl_oe)
		else $error("clock released while waiting");
	chk_stop_release: assert property (@(posedge link_clk)
		disable iff (lrst)
		lk == LK_SP_C && tick |=> lk == LK_IDLE && !scl_oe && !sda_oe)
		else $error("lines not released after stop");
endmodule
`default_nettype wire

// >>> test/i2chs_slave.sv
// Behavioural receiving device on the two-wire bus.
// Assumes pull-ups; bench resolves the wire levels.
`timescale 1ns/1ps
`default_nettype none
module i2chs_slave (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       ack_en,
	output logic            sda_oe,
	output logic [7:0]      rx_byte
);
	int cnt;
	initial begin
		cnt = 0;
		sda_oe = 1'b0;
		rx_byte = 8'h00;
	end
	// Start or repeated start restarts the bit count
	always @(negedge sda) begin
		if (scl === 1'b1)
			cnt = 0;
	end
	always @(posedge scl) begin
		if (cnt < 8)
			rx_byte = {rx_byte[6:0], sda};
		cnt = cnt + 1;
	end
	// Acknowledge slot, released after the ninth clock
	always @(negedge scl) begin
		if (cnt == 8)
			sda_oe = ack_en;
		else if (cnt == 9) begin
			sda_oe = 1'b0;
			cnt = 0;
		end
	end
endmodule
`default_nettype wire

// >>> test/i2chs_master_bench.sv
// Self-checking bench for the two-wire master handshake.
// Assumes the slave model on the far side of the lines.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
	$display("MISMATCH %0t %h %h", $time, (a), (b)); end end
module i2chs_master_bench;
	import i2chs_pkg::*;
	typedef struct {logic st, sp, ack; logic [7:0] d, ex;} i2chs_row_t;
	logic clock = 0, link_clk = 0, rst = 1, ctrl_wr = 0, ctrl_flag = 0;
	logic ctrl_enable = 0, ctrl_start = 0, ctrl_stop = 0, ie = 0, ge = 0;
	logic data_valid = 0, ack_en = 1;
	logic [7:0] data_in = 8'h00;
	logic data_ready, flag, irq_req, busy, scl_oe, sda_oe, s_oe;
	logic [7:0] bus_status_reg, byte_shift_reg, rx;
	wire scl = ~scl_oe;
	wire sda = ~(sda_oe | s_oe);
	int err_count = 0, n_compared = 0;
	i2chs_row_t rows[10] = '{'{1, 0, 1, 8'h00, 8'h08},
		'{0, 0, 1, 8'hA0, 8'h18}, '{0, 0, 1, 8'h5A, 8'h28},
		'{0, 0, 0, 8'hC3, 8'h30}, '{0, 1, 1, 8'h00, 8'hF8},
		'{1, 0, 1, 8'h00, 8'h08}, '{0, 0, 0, 8'h42, 8'h20},
		'{1, 0, 1, 8'h00, 8'h08}, '{0, 0, 1, 8'hA1, 8'h18},
		'{0, 1, 1, 8'h00, 8'hF8}};
	always #20 clock = ~clock;
	always #62.5 link_clk = ~link_clk;
	i2chs_master #(.HALF(1)) u_dut (.clock(clock), .rst(rst),
		.link_clk(link_clk), .ctrl_wr(ctrl_wr), .ctrl_flag(ctrl_flag),
		.ctrl_enable(ctrl_enable), .ctrl_start(ctrl_start),
		.ctrl_stop(ctrl_stop), .irq_enable_bit(ie), .global_irq_en(ge),
		.data_valid(data_valid), .data_ready(data_ready),
		.data_in(data_in), .flag(flag), .bus_status_reg(bus_status_reg),
		.byte_shift_reg(byte_shift_reg), .irq_req(irq_req), .busy(busy),
		.scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
		.sda_out(), .sda_oe(sda_oe));
	i2chs_slave u_slv (.scl(scl), .sda(sda), .ack_en(ack_en),
		.sda_oe(s_oe), .rx_byte(rx));
	task end_of_test;
		if (err_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task cyc(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task push(logic [7:0] d);
		data_in = d;
		data_valid = 1;
		cyc(1);
		data_valid = 0;
		cyc(1);
	endtask
	task wr(logic f, logic st, logic sp);
		ctrl_flag = f;
		ctrl_enable = 1;
		ctrl_start = st;
		ctrl_stop = sp;
		ctrl_wr = 1;
		cyc(1);
		ctrl_wr = 0;
	endtask
	task op(i2chs_row_t r, logic p);
		int k;
		ack_en = r.ack;
		if (p && !r.st && !r.sp)
			push(r.d); // byte loaded first
		wr(1, r.st, r.sp); // control write
		`CHK(flag, 1'b0) // flag cleared
		if (r.sp) begin
			`CHK(busy, 1'b1) // stop begins
			for (k = 0; k < 500 && busy !== 1'b0; k++)
				cyc(1);
			cyc(40);
			`CHK(flag, 1'b0) // no flag after stop
			`CHK({busy, scl, sda}, 3'b011) // lines released
		end else begin
			for (k = 0; k < 500 && flag !== 1'b1; k++)
				cyc(1);
			`CHK(flag, 1'b1) // flag set
			cyc(1);
			`CHK(bus_status_reg & 8'hF8, r.ex) // status
			`CHK(scl_oe, 1'b1) // clock held low
			cyc(1);
			`CHK(irq_req, ie & ge) // interrupt gating
			if (!r.st) begin
				`CHK(rx, r.d) // byte on the wire
				`CHK(u_slv.cnt, 0) // ninth clock done
			end
		end
	endtask
	initial begin
		cyc(10);
		rst = 0;
		cyc(16);
		for (int i = 0; i < 10; i++) begin
			ie = i[0];
			ge = i[1];
			op(rows[i], 1);
		end
		op(rows[0], 1);
		wr(0, 0, 0);
		cyc(40);
		`CHK({flag, busy, scl_oe}, 3'b101) // flag held
		for (int i = 0; i < 16; i++)
			push(8'(8'h10 + i));
		cyc(2);
		`CHK(data_ready, 1'b0) // buffer full
		for (int i = 0; i < 16; i++)
			op('{1'b0, 1'b0, 1'b1, 8'(8'h10 + i),
				(i > 0) ? 8'h28 : 8'h18}, 0); // drained in order
		`CHK(data_ready, 1'b1) // buffer empty again
		op(rows[9], 0);
		op(rows[0], 1);
		rst = 1;
		cyc(10);
		`CHK({flag, busy, bus_status_reg}, 10'h0F8) // reset values
		`CHK({irq_req, byte_shift_reg}, 9'h000) // reset values
		end_of_test;
	end
	initial begin
		#2000000;
		err_count++;
		end_of_test;
	end
endmodule
`default_nettype wire
